/* bench/line_exposure_checker_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module line_exposure_checker (
   input wire sys_clk,
   input wire resetn,
   input wire line_trigger,
   input wire [2:0] exposure_mode,
   input wire exposure_active,
   input wire exposure_start,
   input wire readout_strobe,
   input wire [23:0] measured_period,
   input wire exposure_clamped,
   input wire mode_fault
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_start_single: assert property (exposure_start |=> !exposure_start)
      else $error("start pulse too long");
   a_readout_single: assert property (readout_strobe |=> !readout_strobe)
      else $error("readout pulse too long");
   a_start_active: assert property (exposure_start |-> ##[0:1] exposure_active)
      else $error("start without exposure");
   a_readout_ends: assert property (readout_strobe |-> ##[0:1] !exposure_active)
      else $error("exposure kept after readout");
   a_edge_delay: assert property ((exposure_mode == 3'h0) && $rose(line_trigger) |-> ##[98:102] exposure_start)
      else $error("edge start delay wrong");
   a_edge_readout_time: assert property ((exposure_mode == 3'h0) && $rose(line_trigger) && exposure_active
      |-> ##[30:34] readout_strobe)
      else $error("edge readout time wrong");
   a_prog_delay: assert property (((exposure_mode == 3'h2) && !exposure_clamped && $rose(line_trigger))
      ##1 line_trigger [*5] |-> ##[41:45] exposure_start)
      else $error("programmable start delay wrong");
   a_fault_code: assert property ((exposure_mode > 3'h4) [*4] |-> mode_fault)
      else $error("invalid mode not flagged");
   a_fault_clear: assert property ((exposure_mode <= 3'h4) [*4] |-> !mode_fault)
      else $error("valid mode flagged");
   a_fault_idle: assert property (mode_fault |-> !exposure_active)
      else $error("exposure in invalid mode");
   a_clamp_prog: assert property ((exposure_mode != 3'h2) [*3] |-> !exposure_clamped)
      else $error("clamp outside programmable mode");
   a_free_period: assert property (((exposure_mode == 3'h3) || (exposure_mode == 3'h4)) [*4]
      |-> measured_period == 24'h000000)
      else $error("period measured in free run");
endmodule
bind line_exposure_timing_control line_exposure_checker chk_i (.sys_clk(sys_clk), .resetn(resetn),
   .line_trigger(line_trigger), .exposure_mode(exposure_mode), .exposure_active(exposure_active),
   .exposure_start(exposure_start), .readout_strobe(readout_strobe), .measured_period(measured_period),
   .exposure_clamped(exposure_clamped), .mode_fault(mode_fault));

/* bench/line_trigger_source.sv */
`timescale 1ns/1ps
// ****************************************
// Frame grabber line trigger source
// ****************************************
module line_trigger_source (
   input wire sys_clk,
   input wire run,
   input wire [15:0] hi_cyc,
   input wire [15:0] lo_cyc,
   output reg line_trigger
);
   reg [15:0] cnt;
   initial begin
      cnt = 16'h0000;
      line_trigger = 1'b0;
   end
   always @(negedge sys_clk) begin
      if (!run) begin
         cnt <= 16'h0000;
         line_trigger <= 1'b0;
      end else begin
         // Low phase first, then high; period may change per line
         cnt <= (cnt + 16'h0001 >= lo_cyc + hi_cyc) ? 16'h0000 : cnt + 16'h0001;
         line_trigger <= (cnt >= lo_cyc);
      end
   end
endmodule

/* bench/tb_line_exposure_timing_control.sv */
`timescale 1ns/1ps
module tb_line_exposure_timing_control;
   reg sys_clk, resetn, run, lp_sel, et_sel;
   reg [15:0] hi_cyc, lo_cyc, lp_abs, lp_raw, et_abs, et_raw;
   reg [2:0] mode;
   wire line_trigger, exposure_active, exposure_start, readout_strobe, control_level, exposure_clamped, mode_fault;
   wire [23:0] measured_period;
   integer fails, n_tests, len;
   // ****************************************
   // Design and trigger source
   // ****************************************
   line_trigger_source grabber (.sys_clk(sys_clk), .run(run), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
      .line_trigger(line_trigger));
   line_exposure_timing_control DUT (.sys_clk(sys_clk), .resetn(resetn), .line_trigger(line_trigger),
      .exposure_mode(mode), .line_period_abs(lp_abs), .line_period_raw(lp_raw), .line_period_use_raw(lp_sel),
      .exposure_time_abs(et_abs), .exposure_time_raw(et_raw), .exposure_time_use_raw(et_sel),
      .exposure_active(exposure_active), .exposure_start(exposure_start), .readout_strobe(readout_strobe),
      .control_level(control_level), .measured_period(measured_period), .exposure_clamped(exposure_clamped),
      .mode_fault(mode_fault));
   // ****************************************
   // Tasks
   // ****************************************
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [23:0] got, input [23:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_near(input integer got, input integer exp, input integer tol);
      begin
         n_tests = n_tests + 1;
         if (got < exp - tol || got > exp + tol) begin
            fails = fails + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Cycles from exposure start to readout of the same line
   task measure;
      integer k;
      begin
         k = 0;
         while (exposure_start !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k = k + 1;
         end
         len = 1;
         @(negedge sys_clk);
         while (readout_strobe !== 1'b1 && len < 3000) begin
            @(negedge sys_clk);
            len = len + 1;
         end
      end
   endtask
   task cfg(input [2:0] m, input [15:0] hi, input [15:0] lo, input r);
      begin
         run = 1'b0;
         repeat (300) @(negedge sys_clk);
         mode = m;
         hi_cyc = hi;
         lo_cyc = lo;
         repeat (10) @(negedge sys_clk);
         run = r;
      end
   endtask
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #(25 * 60000);
      fails = fails + 1;
      conclude;
   end
   initial begin
      resetn = 1'b0;
      run = 1'b0;
      mode = 3'h0;
      hi_cyc = 16'h0014;
      lo_cyc = 16'h00C8;
      lp_abs = 16'h0005;
      lp_raw = 16'h003C;
      et_abs = 16'h0002;
      et_raw = 16'h001E;
      lp_sel = 1'b0;
      et_sel = 1'b0;
      fails = 0;
      n_tests = 0;
      len = 0;
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      cfg(3'h0, 16'h0014, 16'h00C8, 1'b1);
      measure;
      measure;
      chk_near(len, 152, 1);
      chk(measured_period, 24'h0000DC);
      lo_cyc = 16'h012C;
      measure;
      measure;
      chk_near(len, 252, 1);
      chk(measured_period, 24'h000140);
      cfg(3'h1, 16'h0064, 16'h00C8, 1'b1);
      measure;
      measure;
      chk_near(len, 236, 2);
      cfg(3'h2, 16'h0014, 16'h00C8, 1'b1);
      measure;
      chk_near(len, 80, 1);
      et_sel = 1'b1;
      measure;
      measure;
      chk_near(len, 120, 1);
      et_sel = 1'b0;
      et_abs = 16'h0005;
      measure;
      measure;
      measure;
      chk_near(len, 152, 1);
      chk(exposure_clamped, 24'h000001);
      et_abs = 16'h0002;
      cfg(3'h2, 16'h0002, 16'h00C8, 1'b1);
      len = 0;
      repeat (600) begin
         @(negedge sys_clk);
         if (exposure_start === 1'b1)
            len = len + 1;
      end
      chk(len, 24'h000000);
      cfg(3'h3, 16'h0014, 16'h00C8, 1'b0);
      measure;
      measure;
      chk_near(len, 132, 1);
      chk(measured_period, 24'h000000);
      lp_sel = 1'b1;
      measure;
      measure;
      chk_near(len, 172, 1);
      lp_sel = 1'b0;
      cfg(3'h4, 16'h0014, 16'h00C8, 1'b0);
      measure;
      measure;
      chk_near(len, 80, 1);
      // Control signal low time over one full line period
      len = 0;
      repeat (200) begin
         @(negedge sys_clk);
         if (control_level === 1'b0)
            len = len + 1;
      end
      chk(len, 24'h000050);
      cfg(3'h6, 16'h0014, 16'h00C8, 1'b0);
      chk(mode_fault, 24'h000001);
      chk(exposure_active, 24'h000000);
      conclude;
   end
endmodule

/* hw/interval_timer.v */
`timescale 1ns/1ps
module interval_timer (
   input wire sys_clk,
   input wire resetn,
   input wire load,
   input wire cancel,
   input wire [23:0] value,
   output reg done,
   output wire busy
);
   reg [23:0] count;

   assign busy = (count != 24'h000000);

   // ****************************************
   // Down counter, done pulse value cycles after load
   // ****************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count <= 24'h000000;
         done <= 1'b0;
      end else begin
         done <= (count == 24'h000001) && !load && !cancel;
         if (cancel)
            count <= 24'h000000;
         else if (load)
            count <= (value == 24'h000000) ? 24'h000001 : value;
         else if (count != 24'h000000)
            count <= count - 24'h000001;
      end
   end
endmodule

/* hw/line_exposure_defines.vh */
`ifndef LINE_EXPOSURE_DEFINES_VH
`define LINE_EXPOSURE_DEFINES_VH
// ****************************************
// Clock and unit conversion
// ****************************************
`define CLK_PERIOD_NS 25
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define RAW_TICK_NS 100
`define CYC_PER_RAW (`RAW_TICK_NS / `CLK_PERIOD_NS)
`define TIME_W 24
// ****************************************
// Exposure mode field encodings
// ****************************************
`define MODE_TRIG_EDGE 3'h0
`define MODE_TRIG_LEVEL 3'h1
`define MODE_TRIG_PROG 3'h2
`define MODE_FREE_EDGE 3'h3
`define MODE_FREE_PROG 3'h4
// ****************************************
// Trigger width limits
// ****************************************
`define HI_MIN_LEVEL_NS 2000
`define HI_MIN_LEVEL_CYC ((`HI_MIN_LEVEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HI_MIN_EDGE_NS 100
`define HI_MIN_EDGE_CYC ((`HI_MIN_EDGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LO_MIN_NS 2000
`define LO_MIN_CYC ((`LO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ****************************************
// Exposure timing
// ****************************************
`define EDGE_LOSS_NS 1700
`define EDGE_LOSS_CYC ((`EDGE_LOSS_NS + `CLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define PROG_MARGIN_NS 1200
`define PROG_MARGIN_CYC ((`PROG_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_PROG_NS 1210
`define DELAY_PROG_CYC ((`DELAY_PROG_NS + `CLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define DELAY_EDGE_NS 2510
`define DELAY_EDGE_CYC ((`DELAY_EDGE_NS + `CLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define EDGE_END_CYC (`DELAY_EDGE_CYC - `EDGE_LOSS_CYC)
`define SYNC_CYC 3
`define OUT_REG_CYC 1
`endif

/* hw/line_exposure_timing_control.v */
// Summary of operation
// - Triggered: one line per trigger period, rate is one over rise-to-rise time.
// - Trigger may be periodic or not; period may change every line.
// - Triggered offers edge, level and programmable exposure modes.
// - Triggered edge: expose rise to rise, read out at rise, fall ignored.
// - Triggered level: expose while low, read out at rise.
// - Triggered programmable: expose programmed time from rise, then read out.
// - Mode comes from the exposure mode input field.
// - Edge mode exposure equals line period minus 1.7 us.
// - Programmed exposure over period minus 1.2 us falls back to edge mode.
// - Start delay counts from rise, or from fall in level mode.
// - Start delay 1.21 us programmable and level, 2.51 us edge.
// - Free run: internal control signal paces lines at one over period.
// - Free run offers edge and programmable modes on the same field.
// - Free-run edge: expose period minus 1.7 us, read out at each internal rise.
// - Free-run programmable: control low for exposure time, read out at rise.
// - Line period given in microseconds or raw units, selectable.
// - Exposure time given in microseconds or raw units, selectable.
`timescale 1ns/1ps
`include "line_exposure_defines.vh"
module line_exposure_timing_control (
   input wire sys_clk,
   input wire resetn,
   input wire line_trigger,
   input wire [2:0] exposure_mode,
   input wire [15:0] line_period_abs,
   input wire [15:0] line_period_raw,
   input wire line_period_use_raw,
   input wire [15:0] exposure_time_abs,
   input wire [15:0] exposure_time_raw,
   input wire exposure_time_use_raw,
   output reg exposure_active,
   output reg exposure_start,
   output reg readout_strobe,
   output reg control_level,
   output reg [23:0] measured_period,
   output reg exposure_clamped,
   output reg mode_fault
);
   // ****************************************
   // Constants
   // ****************************************
   localparam [2:0] ST_OFF = 3'b001;
   localparam [2:0] ST_IDLE = 3'b010;
   localparam [2:0] ST_EXPOSE = 3'b100;

   // ****************************************
   // Timing counts, full width then trimmed
   // ****************************************
   localparam [31:0] HI_LEVEL_W = `HI_MIN_LEVEL_CYC;
   localparam [31:0] HI_EDGE_W = `HI_MIN_EDGE_CYC;
   localparam [31:0] LO_MIN_W = `LO_MIN_CYC;
   localparam [31:0] D_EDGE_W = `DELAY_EDGE_CYC;
   localparam [31:0] D_PROG_W = `DELAY_PROG_CYC;
   localparam [31:0] E_END_W = `EDGE_END_CYC;
   localparam [31:0] MARGIN_W = `PROG_MARGIN_CYC;
   localparam [31:0] SYNC_LAT_W = `SYNC_CYC;
   localparam [31:0] OUT_LAT_W = `OUT_REG_CYC;

   localparam [7:0] HI_LEVEL = HI_LEVEL_W[7:0];
   localparam [7:0] HI_EDGE = HI_EDGE_W[7:0];
   localparam [7:0] LO_MIN = LO_MIN_W[7:0];
   localparam [23:0] D_EDGE = D_EDGE_W[23:0];
   localparam [23:0] D_PROG = D_PROG_W[23:0];
   localparam [23:0] E_END = E_END_W[23:0];
   localparam [23:0] MARGIN = MARGIN_W[23:0];
   localparam [23:0] SYNC_LAT = SYNC_LAT_W[23:0];
   localparam [23:0] OUT_LAT = OUT_LAT_W[23:0];

   // ****************************************
   // Declarations
   // ****************************************
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] mode_q;
   reg [23:0] period_cyc;
   reg [23:0] exp_cyc;
   reg [23:0] phase;
   reg [23:0] per_cnt;
   reg ctrl_int;
   reg load_start;
   reg load_end;
   reg [23:0] start_val;
   reg [23:0] end_val;
   reg begin_now;
   reg end_now;
   wire [31:0] lp_abs_cyc;
   wire [31:0] lp_raw_cyc;
   wire [31:0] ex_abs_cyc;
   wire [31:0] ex_raw_cyc;
   wire [7:0] hi_min;
   wire [23:0] lat;
   wire [23:0] fall_point;
   wire [24:0] prog_need;
   wire q_level;
   wire q_rise;
   wire q_fall;
   wire start_done;
   wire end_done;
   wire m_te;
   wire m_tl;
   wire m_tp;
   wire m_fe;
   wire m_fp;
   wire trig;
   wire free;
   wire valid;
   wire mode_chg;
   wire too_long;
   wire eff_edge;
   wire eff_level;
   wire eff_tprog;
   wire int_rise;
   wire int_fall;
   wire rise_ev;
   wire fall_ev;
   wire cancel;

   // ****************************************
   // Mode decode
   // ****************************************
   assign m_te = (exposure_mode == `MODE_TRIG_EDGE);
   assign m_tl = (exposure_mode == `MODE_TRIG_LEVEL);
   assign m_tp = (exposure_mode == `MODE_TRIG_PROG);
   assign m_fe = (exposure_mode == `MODE_FREE_EDGE);
   assign m_fp = (exposure_mode == `MODE_FREE_PROG);
   assign trig = m_te | m_tl | m_tp;
   assign free = m_fe | m_fp;
   assign valid = trig | free;
   assign mode_chg = (exposure_mode != mode_q);

   // ****************************************
   // Period and exposure conversion
   // ****************************************
   assign lp_abs_cyc = line_period_abs * `CYC_PER_US;
   assign lp_raw_cyc = line_period_raw * `CYC_PER_RAW;
   assign ex_abs_cyc = exposure_time_abs * `CYC_PER_US;
   assign ex_raw_cyc = exposure_time_raw * `CYC_PER_RAW;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         period_cyc <= 24'h000000;
         exp_cyc <= 24'h000000;
         mode_q <= `MODE_TRIG_EDGE;
      end else begin
         period_cyc <= line_period_use_raw ? lp_raw_cyc[23:0] : lp_abs_cyc[23:0];
         exp_cyc <= exposure_time_use_raw ? ex_raw_cyc[23:0] : ex_abs_cyc[23:0];
         mode_q <= exposure_mode;
      end
   end

   // ****************************************
   // Trigger qualification
   // ****************************************
   assign hi_min = m_tl ? HI_LEVEL : HI_EDGE;

   trigger_qualifier u_qual (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pin(line_trigger),
      .hi_min(hi_min),
      .lo_min(LO_MIN),
      .level(q_level),
      .rise(q_rise),
      .fall(q_fall)
   );

   // ****************************************
   // Trigger period measurement
   // ****************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         per_cnt <= 24'h000000;
         measured_period <= 24'h000000;
      end else if (!trig) begin
         per_cnt <= 24'h000000;
         measured_period <= 24'h000000;
      end else if (q_rise) begin
         per_cnt <= 24'h000001;
         measured_period <= per_cnt;
      end else if (per_cnt != 24'hFFFFFF) begin
         per_cnt <= per_cnt + 24'h000001;
      end
   end

   assign prog_need = {1'b0, exp_cyc} + {1'b0, MARGIN};
   assign too_long = (measured_period != 24'h000000) && (prog_need > {1'b0, measured_period});

   // ****************************************
   // Free-run internal control signal
   // ****************************************
   assign fall_point = m_fp ? ((exp_cyc >= period_cyc) ? 24'h000001 : period_cyc - exp_cyc)
                            : {1'b0, period_cyc[23:1]};

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         phase <= 24'h000000;
         ctrl_int <= 1'b0;
      end else if (!free || mode_chg) begin
         phase <= 24'h000000;
         ctrl_int <= 1'b0;
      end else begin
         if (phase + 24'h000001 >= period_cyc)
            phase <= 24'h000000;
         else
            phase <= phase + 24'h000001;
         if (int_rise)
            ctrl_int <= 1'b1;
         else if (int_fall)
            ctrl_int <= 1'b0;
      end
   end

   assign int_rise = free && !mode_chg && (phase == 24'h000000);
   assign int_fall = free && !mode_chg && (phase == fall_point) && (phase != 24'h000000);

   // ****************************************
   // Event selection
   // ****************************************
   assign rise_ev = trig ? q_rise : int_rise;
   assign fall_ev = trig ? q_fall : int_fall;
   assign eff_edge = m_te | m_fe | (m_tp & too_long);
   assign eff_level = m_tl;
   assign eff_tprog = m_tp & !too_long;
   assign lat = trig ? (SYNC_LAT + {16'h0000, hi_min} + OUT_LAT) : OUT_LAT;
   assign cancel = mode_chg | !valid;

   always @* begin
      load_start = 1'b0;
      load_end = 1'b0;
      start_val = 24'h000000;
      end_val = 24'h000000;
      begin_now = 1'b0;
      end_now = 1'b0;
      if (valid && !mode_chg) begin
         if (rise_ev && eff_edge) begin
            load_start = 1'b1;
            start_val = D_EDGE - lat;
            if (state == ST_EXPOSE) begin
               load_end = 1'b1;
               end_val = E_END - lat;
            end
         end
         if (rise_ev && eff_tprog) begin
            load_start = 1'b1;
            start_val = D_PROG - lat;
         end
         if (start_done && eff_tprog) begin
            load_end = 1'b1;
            end_val = (exp_cyc > OUT_LAT) ? exp_cyc - OUT_LAT : 24'h000001;
         end
         if (fall_ev && eff_level) begin
            load_start = 1'b1;
            start_val = D_PROG - SYNC_LAT - OUT_LAT;
         end
         if (rise_ev && (eff_level || m_fp) && state == ST_EXPOSE)
            end_now = 1'b1;
         if (fall_ev && m_fp)
            begin_now = 1'b1;
      end
   end

   // ****************************************
   // Delay and exposure timers
   // ****************************************
   interval_timer u_start (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .load(load_start),
      .cancel(cancel),
      .value(start_val),
      .done(start_done),
      .busy()
   );

   interval_timer u_end (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .load(load_end),
      .cancel(cancel),
      .value(end_val),
      .done(end_done),
      .busy()
   );

   // ****************************************
   // Exposure state machine
   // ****************************************
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (valid)
               next_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (cancel)
               next_state = ST_OFF;
            else if (start_done || begin_now)
               next_state = ST_EXPOSE;
         end
         ST_EXPOSE: begin
            if (cancel)
               next_state = ST_OFF;
            else if (end_done || end_now)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_OFF;
         exposure_active <= 1'b0;
         exposure_start <= 1'b0;
         readout_strobe <= 1'b0;
      end else begin
         state <= next_state;
         exposure_active <= (next_state == ST_EXPOSE);
         exposure_start <= (state != ST_EXPOSE) && (next_state == ST_EXPOSE);
         readout_strobe <= (state == ST_EXPOSE) && (next_state == ST_IDLE);
      end
   end

   // ****************************************
   // Status outputs
   // ****************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         control_level <= 1'b0;
         exposure_clamped <= 1'b0;
         mode_fault <= 1'b0;
      end else begin
         control_level <= free ? ctrl_int : q_level;
         exposure_clamped <= m_tp & too_long;
         mode_fault <= !valid;
      end
   end
endmodule

/* hw/trigger_qualifier.v */
`timescale 1ns/1ps
module trigger_qualifier (
   input wire sys_clk,
   input wire resetn,
   input wire pin,
   input wire [7:0] hi_min,
   input wire [7:0] lo_min,
   output reg level,
   output reg rise,
   output reg fall
);
   reg sync_a;
   reg sync_b;
   reg prev;
   reg low_ok;
   reg [7:0] run;

   // ****************************************
   // Two-stage synchroniser and width filter
   // ****************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
         run <= 8'h00;
         low_ok <= 1'b0;
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
         prev <= sync_b;
         rise <= 1'b0;
         fall <= 1'b0;
         if (sync_b != prev)
            run <= 8'h01;
         else if (run != 8'hFF)
            run <= run + 8'h01;
         if (!level) begin
            if (!sync_b && run >= lo_min)
               low_ok <= 1'b1;
            if (sync_b && low_ok && sync_b == prev && run >= hi_min) begin
               level <= 1'b1;
               rise <= 1'b1;
               low_ok <= 1'b0;
            end
         end else if (!sync_b) begin
            level <= 1'b0;
            fall <= 1'b1;
         end
      end
   end
endmodule
